// ==== hdl/pis_ctrl.v ====
// prioritized vectored interrupt source collector and arbiter
// assumes peripheral event strobes are one-cycle pulses on clk; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "pis_defs.vh"

// Function
// - fixed priority 0..16, vector per group
// - global mask blocks all but software trap
// - breakpoint forces non-maskable software trap
// - low external pin latches masked request
// - lock indicator change sets lock flag
// - lock flag requests only when enabled
// - timer wrap sets flag, enable gates
// - channel event sets flag, enable gates
// - sync receive load sets rx-full flag
// - sync transmit load sets tx-empty flag
// - slave select rise mid-transfer sets fault
// - master select low sets fault, error-gated
// - sync byte before read sets overflow
// - async handoff sets tx-empty flag
// - async both empty, no break: done
// - async delivery sets rx-full flag
// - ten or eleven ones set idle
// - async character before read: overrun
// - async noise sets noise flag
// - zero stop bit sets framing flag
// - parity failure sets parity flag
// - async errors merge into priority 11
// - at boundary present highest pending request
// - latched service not preempted; sets mask
module pis_ctrl (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ext_request_pin_n,
    input  wire        ext_request_mask,
    input  wire        lock_indicator,
    input  wire        lock_change_int_en,
    input  wire [1:0]  timer_one_channel_event,
    input  wire [1:0]  timer_one_channel_event_int_en,
    input  wire        timer_one_wrap,
    input  wire        timer_one_wrap_int_en,
    input  wire [1:0]  timer_two_channel_event,
    input  wire [1:0]  timer_two_channel_event_int_en,
    input  wire        timer_two_wrap,
    input  wire        timer_two_wrap_int_en,
    input  wire        sync_rx_load,
    input  wire        sync_rx_int_en,
    input  wire        sync_tx_load,
    input  wire        sync_tx_int_en,
    input  wire        sync_master,
    input  wire        sync_transfer_active,
    input  wire        sync_select_pin,
    input  wire        select_fault_detect_en,
    input  wire        sync_error_int_en,
    input  wire        async_tx_handoff,
    input  wire        async_tx_int_en,
    input  wire        async_tx_shift_empty,
    input  wire        async_tx_data_empty,
    input  wire        async_break_idle_busy,
    input  wire        async_tx_done_int_en,
    input  wire        async_rx_deliver,
    input  wire        async_rx_int_en,
    input  wire        async_rxd_pin,
    input  wire        async_bit_tick,
    input  wire        async_nine_bit,
    input  wire        line_idle_int_en,
    input  wire        async_overrun_int_en,
    input  wire        async_noise_detect,
    input  wire        async_noise_int_en,
    input  wire        async_stop_sample,
    input  wire        async_stop_bit,
    input  wire        async_frame_err_int_en,
    input  wire        async_parity_check,
    input  wire        async_parity_fail,
    input  wire        async_parity_err_int_en,
    input  wire        key_pin_req,
    input  wire        conversion_req,
    input  wire        tick_req,
    input  wire [19:0] flag_clear,
    input  wire        instr_boundary,
    input  wire        software_trap_instruction,
    input  wire        break_hit,
    input  wire        global_mask_clear,
    input  wire        global_mask_set,
    input  wire        int_ack,
    output reg  [19:0] flags_reg,
    output reg  [16:1] pending_source_flags,
    output reg         global_mask_reg,
    output reg         int_req_reg,
    output reg  [15:0] int_vector_reg,
    output reg  [4:0]  int_priority_reg
);

    // ************************************************
    // pin synchronisers: ext, lock, select, rxd
    // ************************************************
    reg  [3:0]  pin_meta_reg;
    reg  [3:0]  pin_sync_reg;
    reg  [3:0]  pin_last_reg;
    wire        ext_low      = ~pin_sync_reg[0];
    wire        lock_s       = pin_sync_reg[1];
    wire        sel_s        = pin_sync_reg[2];
    wire        rxd_s        = pin_sync_reg[3];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 4'hF;
            pin_sync_reg <= 4'hF;
            pin_last_reg <= 4'hF;
        end else begin
            pin_meta_reg <= {async_rxd_pin, sync_select_pin, lock_indicator, ext_request_pin_n};
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    // ************************************************
    // idle line counter and done-condition edge
    // ************************************************
    reg  [3:0]  idle_cnt_reg;
    reg  [3:0]  idle_cnt_next;
    reg         idle_hit;
    reg         tx_idle_last_reg;
    wire [3:0]  idle_need    = async_nine_bit ? `PIS_IDLE_LONG : `PIS_IDLE_SHORT;
    wire        tx_idle_now  = async_tx_shift_empty & async_tx_data_empty
                               & ~async_break_idle_busy;

    always @* begin
        idle_cnt_next = idle_cnt_reg;
        idle_hit      = 1'b0;
        if (async_bit_tick) begin
            if (!rxd_s) begin
                idle_cnt_next = 4'h0;
            end else if (idle_cnt_reg < idle_need) begin
                idle_cnt_next = idle_cnt_reg + 4'h1;
                idle_hit      = (idle_cnt_next == idle_need);
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_reg     <= 4'h0;
            // an idle transmitter at reset is not a completion
            tx_idle_last_reg <= 1'b1;
        end else begin
            idle_cnt_reg     <= idle_cnt_next;
            tx_idle_last_reg <= tx_idle_now;
        end
    end

    // ************************************************
    // flag set conditions
    // ************************************************
    reg  [19:0] flag_set;

    always @* begin
        flag_set = 20'h00000;
        flag_set[`PIS_F_EXT]      = ext_low;
        flag_set[`PIS_F_LOCK]     = lock_s ^ pin_last_reg[1];
        flag_set[`PIS_F_T1C0]     = timer_one_channel_event[0];
        flag_set[`PIS_F_T1C1]     = timer_one_channel_event[1];
        flag_set[`PIS_F_T1WRAP]   = timer_one_wrap;
        flag_set[`PIS_F_T2C0]     = timer_two_channel_event[0];
        flag_set[`PIS_F_T2C1]     = timer_two_channel_event[1];
        flag_set[`PIS_F_T2WRAP]   = timer_two_wrap;
        flag_set[`PIS_F_SRXFULL]  = sync_rx_load;
        // previous byte unread: flag still up and not being cleared now
        flag_set[`PIS_F_SOVF]     = sync_rx_load & flags_reg[`PIS_F_SRXFULL]
                                    & ~flag_clear[`PIS_F_SRXFULL];
        flag_set[`PIS_F_SFAULT]   = select_fault_detect_en & (sync_master
                                    ? (~sel_s & pin_last_reg[2])
                                    : (sel_s & ~pin_last_reg[2] & sync_transfer_active));
        flag_set[`PIS_F_STXEMPTY] = sync_tx_load;
        flag_set[`PIS_F_AOVR]     = async_rx_deliver & flags_reg[`PIS_F_ARXFULL]
                                    & ~flag_clear[`PIS_F_ARXFULL];
        flag_set[`PIS_F_ANOISE]   = async_noise_detect;
        flag_set[`PIS_F_AFRAME]   = async_stop_sample & ~async_stop_bit;
        flag_set[`PIS_F_APARITY]  = async_parity_check & async_parity_fail;
        flag_set[`PIS_F_ARXFULL]  = async_rx_deliver;
        flag_set[`PIS_F_AIDLE]    = idle_hit;
        flag_set[`PIS_F_ATXEMPTY] = async_tx_handoff;
        flag_set[`PIS_F_ATXDONE]  = tx_idle_now & ~tx_idle_last_reg;
    end

    // ************************************************
    // sticky flags, set wins over clear
    // ************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `PIS_NFLAG; gi = gi + 1) begin : g_flag
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flags_reg[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flags_reg[gi] <= 1'b1;
                end else if (flag_clear[gi]) begin
                    flags_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ************************************************
    // per-source requests, flag and enable, grouped; 14..16 taken direct
    // ************************************************
    reg  [16:1] src_req;

    always @* begin
        src_req     = `PIS_PEND_RST;
        src_req[1]  = flags_reg[`PIS_F_EXT] & ~ext_request_mask;
        src_req[2]  = flags_reg[`PIS_F_LOCK] & lock_change_int_en;
        src_req[3]  = flags_reg[`PIS_F_T1C0] & timer_one_channel_event_int_en[0];
        src_req[4]  = flags_reg[`PIS_F_T1C1] & timer_one_channel_event_int_en[1];
        src_req[5]  = flags_reg[`PIS_F_T1WRAP] & timer_one_wrap_int_en;
        src_req[6]  = flags_reg[`PIS_F_T2C0] & timer_two_channel_event_int_en[0];
        src_req[7]  = flags_reg[`PIS_F_T2C1] & timer_two_channel_event_int_en[1];
        src_req[8]  = flags_reg[`PIS_F_T2WRAP] & timer_two_wrap_int_en;
        src_req[9]  = (flags_reg[`PIS_F_SRXFULL] & sync_rx_int_en)
                    | ((flags_reg[`PIS_F_SOVF] | flags_reg[`PIS_F_SFAULT])
                       & sync_error_int_en);
        src_req[10] = flags_reg[`PIS_F_STXEMPTY] & sync_tx_int_en;
        src_req[11] = (flags_reg[`PIS_F_AOVR] & async_overrun_int_en)
                    | (flags_reg[`PIS_F_ANOISE] & async_noise_int_en)
                    | (flags_reg[`PIS_F_AFRAME] & async_frame_err_int_en)
                    | (flags_reg[`PIS_F_APARITY] & async_parity_err_int_en);
        src_req[12] = (flags_reg[`PIS_F_ARXFULL] & async_rx_int_en)
                    | (flags_reg[`PIS_F_AIDLE] & line_idle_int_en);
        src_req[13] = (flags_reg[`PIS_F_ATXEMPTY] & async_tx_int_en)
                    | (flags_reg[`PIS_F_ATXDONE] & async_tx_done_int_en);
        src_req[14] = key_pin_req;
        src_req[15] = conversion_req;
        src_req[16] = tick_req;
    end

    // ************************************************
    // fixed-priority pick, lowest number wins
    // ************************************************
    reg  [4:0]  pick_prio;
    reg         pick_any;
    integer     pi;

    always @* begin
        pick_prio = `PIS_PRIO_LAST;
        pick_any  = 1'b0;
        for (pi = `PIS_NSRC; pi >= 1; pi = pi - 1) begin
            if (src_req[pi]) begin
                pick_prio = pi[4:0];
                pick_any  = 1'b1;
            end
        end
    end

    // vector walks down two bytes per priority step from the trap vector
    wire [15:0] pick_vector = `PIS_VEC_SWI - ({11'h000, pick_prio} << 1);

    // ************************************************
    // service latch and global mask
    // ************************************************
    reg         trap_pend_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_source_flags <= `PIS_PEND_RST;
            global_mask_reg      <= `PIS_MASK_RST;
            int_req_reg          <= 1'b0;
            int_vector_reg       <= `PIS_VEC_RESET;
            int_priority_reg     <= `PIS_PRIO_SWI;
            trap_pend_reg        <= 1'b0;
        end else begin
            pending_source_flags <= src_req;
            if (software_trap_instruction | break_hit) begin
                trap_pend_reg <= 1'b1;
            end
            if (int_req_reg) begin
                // held until taken; nothing can replace it meanwhile
                if (int_ack) begin
                    int_req_reg <= 1'b0;
                end
            end else if (instr_boundary & trap_pend_reg) begin
                int_req_reg      <= 1'b1;
                int_vector_reg   <= `PIS_VEC_SWI;
                int_priority_reg <= `PIS_PRIO_SWI;
                // a trap arriving in the taking cycle stays queued
                trap_pend_reg    <= software_trap_instruction | break_hit;
                global_mask_reg  <= 1'b1;
            end else if (instr_boundary & pick_any & ~global_mask_reg) begin
                int_req_reg      <= 1'b1;
                int_vector_reg   <= pick_vector;
                int_priority_reg <= pick_prio;
                global_mask_reg  <= 1'b1;
            end else if (global_mask_set) begin
                global_mask_reg  <= 1'b1;
            end else if (global_mask_clear) begin
                global_mask_reg  <= 1'b0;
            end
        end
    end

endmodule // pis_ctrl

`default_nettype wire

// ==== hdl/pis_defs.vh ====
// constants for the prioritized interrupt source block
// assumes the includer defines nothing with a pis_ prefix
`ifndef PIS_DEFS_VH
`define PIS_DEFS_VH

// ************************************************
// flag indices in the sticky flag vector
// ************************************************
`define PIS_NFLAG        20
`define PIS_F_EXT        0
`define PIS_F_LOCK       1
`define PIS_F_T1C0       2
`define PIS_F_T1C1       3
`define PIS_F_T1WRAP     4
`define PIS_F_T2C0       5
`define PIS_F_T2C1       6
`define PIS_F_T2WRAP     7
`define PIS_F_SRXFULL    8
`define PIS_F_SOVF       9
`define PIS_F_SFAULT     10
`define PIS_F_STXEMPTY   11
`define PIS_F_AOVR       12
`define PIS_F_ANOISE     13
`define PIS_F_AFRAME     14
`define PIS_F_APARITY    15
`define PIS_F_ARXFULL    16
`define PIS_F_AIDLE      17
`define PIS_F_ATXEMPTY   18
`define PIS_F_ATXDONE    19

// ************************************************
// reset values
// ************************************************
`define PIS_FLAGS_RST    20'h00000
`define PIS_PEND_RST     16'h0000
`define PIS_MASK_RST     1'b1

// ************************************************
// priority and vector map
// ************************************************
`define PIS_NSRC         16
`define PIS_PRIO_SWI     5'h00
`define PIS_PRIO_LAST    5'h10
`define PIS_VEC_RESET    16'hFFFE
`define PIS_VEC_SWI      16'hFFFC
`define PIS_VEC_STEP     16'h0002

// ************************************************
// idle line detection, consecutive ones
// ************************************************
`define PIS_IDLE_SHORT   4'hA
`define PIS_IDLE_LONG    4'hB

`endif

// ==== tb/pis_chk.sv ====
// checker for the prioritized interrupt source collector
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module pis_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        instr_boundary,
    input wire logic        int_ack,
    input wire logic        timer_one_wrap,
    input wire logic        timer_one_wrap_int_en,
    input wire logic        lock_change_int_en,
    input wire logic [19:0] flag_clear,
    input wire logic [19:0] flags_reg,
    input wire logic [16:1] pending_source_flags,
    input wire logic        global_mask_reg,
    input wire logic        int_req_reg,
    input wire logic [15:0] int_vector_reg,
    input wire logic [4:0]  int_priority_reg
);
    // ************************************************
    // service handshake and source gating
    // ************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_req_holds: assert property (
        int_req_reg && !int_ack |=> int_req_reg && $stable(int_vector_reg)
        && $stable(int_priority_reg)) else $error("request moved before ack");
    a_entry_masks: assert property (
        $rose(int_req_reg) |-> global_mask_reg) else $error("entry left mask clear");
    a_ack_drops: assert property (
        int_req_reg && int_ack |=> !int_req_reg) else $error("request kept after ack");
    a_vector_map: assert property (
        int_req_reg |-> int_priority_reg <= 5'h10 && int_vector_reg ==
        16'hFFFC - {10'h000, int_priority_reg, 1'b0}) else $error("vector mismatch");
    a_mask_blocks: assert property (
        $rose(int_req_reg) && int_priority_reg != 5'h00 |-> !$past(global_mask_reg))
        else $error("maskable request taken while masked");
    a_boundary_only: assert property (
        $rose(int_req_reg) |-> $past(instr_boundary)) else $error("latch off boundary");
    a_wrap_sets: assert property (
        timer_one_wrap |=> flags_reg[4]) else $error("wrap flag not set");
    a_wrap_clears: assert property (
        flag_clear[4] && !timer_one_wrap |=> !flags_reg[4]) else $error("wrap flag kept");
    a_wrap_gate: assert property (
        flags_reg[4] && !timer_one_wrap_int_en |=> !pending_source_flags[5])
        else $error("disabled wrap pending");
    a_lock_gate: assert property (
        $rose(pending_source_flags[2]) |-> $past(lock_change_int_en && flags_reg[1]))
        else $error("lock pending without enable");
endmodule // pis_chk
bind pis_ctrl pis_chk u_chk (.*);
`default_nettype wire

// ==== tb/pis_core_model.sv ====
// processor core model: one instruction boundary per idle cycle, acks requests
// assumes it is driven by the same clock as the collector
`timescale 1ns/1ps
`default_nettype none
module pis_core_model #(
    parameter int ACK_DLY = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic int_req_reg,
    output var  logic instr_boundary,
    output var  logic int_ack
);
    int cnt;
    // ************************************************
    // slow acknowledge, held request is never pre-empted
    // ************************************************
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_boundary <= 1'b0;
            int_ack        <= 1'b0;
            cnt            <= 0;
        end else begin
            int_ack        <= 1'b0;
            instr_boundary <= !int_req_reg;
            if (int_req_reg && !int_ack) begin
                cnt <= cnt + 1;
                if (cnt == ACK_DLY) begin
                    int_ack <= 1'b1;
                    cnt     <= 0;
                end
            end
        end
    end
endmodule // pis_core_model
`default_nettype wire

// ==== tb/pis_ctrl_tb.sv ====
// testbench for the prioritized interrupt source collector
// assumes pis_ctrl, pis_chk and pis_core_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module pis_ctrl_tb;
    // ************************************************
    // stimulus, core model and collector
    // ************************************************
    logic        clk = 0, rst_n = 0, ext_request_pin_n = 1, lock_indicator = 1;
    logic        sync_master = 0, sync_transfer_active = 0, sync_select_pin = 1;
    logic        async_tx_shift_empty = 0, async_tx_data_empty = 0, async_rxd_pin = 1;
    logic        async_break_idle_busy = 0, global_mask_clear = 0, global_mask_set = 0;
    logic [19:0] flag_clear = 0;
    logic [18:0] en = '1;
    logic [15:0] ev = 0;
    logic [2:0]  lv = 0;
    logic        ext_request_mask = 1'b0, async_stop_bit = 1'b0;
    logic        async_parity_fail = 1'b1, async_nine_bit = 1'b0;
    wire         instr_boundary, int_ack, global_mask_reg, int_req_reg;
    wire [19:0]  flags_reg;
    wire [16:1]  pending_source_flags;
    wire [15:0]  int_vector_reg;
    wire [4:0]   int_priority_reg;
    wire         timer_one_wrap, timer_two_wrap, sync_rx_load, sync_tx_load, async_tx_handoff;
    wire         async_rx_deliver, async_noise_detect, async_stop_sample, async_parity_check;
    wire         software_trap_instruction, break_hit, async_bit_tick;
    wire         key_pin_req, conversion_req, tick_req;
    wire [1:0]   timer_one_channel_event, timer_two_channel_event;
    wire [1:0]   timer_one_channel_event_int_en, timer_two_channel_event_int_en;
    wire         lock_change_int_en, timer_one_wrap_int_en, timer_two_wrap_int_en;
    wire         sync_rx_int_en, sync_tx_int_en, select_fault_detect_en, sync_error_int_en;
    wire         async_tx_int_en, async_tx_done_int_en, async_rx_int_en, line_idle_int_en;
    wire         async_overrun_int_en, async_noise_int_en;
    wire         async_frame_err_int_en, async_parity_err_int_en;
    int          n_mismatch = 0, tests_run = 0, cycles = 0;
    int          fl[13] = '{2, 3, 4, 5, 6, 7, 8, 11, 18, 16, 13, 14, 15};
    int          sr[13] = '{3, 4, 5, 6, 7, 8, 9, 10, 13, 12, 11, 11, 11};
    assign {async_bit_tick, break_hit, software_trap_instruction, async_parity_check,
            async_stop_sample, async_noise_detect, async_rx_deliver, async_tx_handoff,
            sync_tx_load, sync_rx_load, timer_two_wrap, timer_two_channel_event,
            timer_one_wrap, timer_one_channel_event} = ev;
    assign {lock_change_int_en, timer_one_channel_event_int_en, timer_one_wrap_int_en,
            timer_two_channel_event_int_en, timer_two_wrap_int_en, sync_rx_int_en,
            sync_tx_int_en, select_fault_detect_en, sync_error_int_en, async_tx_int_en,
            async_tx_done_int_en, async_rx_int_en, line_idle_int_en, async_overrun_int_en,
            async_noise_int_en, async_frame_err_int_en, async_parity_err_int_en} = en;
    assign {tick_req, conversion_req, key_pin_req} = lv;
    pis_ctrl u_dut (.*);
    pis_core_model #(.ACK_DLY(4)) u_core (.*);
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            test_done();
        end
    end
    // ************************************************
    // helpers
    // ************************************************
    task automatic chk(input string s, input logic [19:0] e, input logic [19:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic fire(input int i);
        ev[i] = 1'b1;
        cyc(1);
        ev[i] = 1'b0;
        cyc(1);
    endtask
    task automatic msk(input bit s);
        if (s) global_mask_set = 1'b1;
        else global_mask_clear = 1'b1;
        cyc(1);
        global_mask_set = 1'b0;
        global_mask_clear = 1'b0;
    endtask
    task automatic clean();
        flag_clear = '1;
        cyc(1);
        flag_clear = 0;
        msk(0);
    endtask
    task automatic quiet();
        cyc(8);
        chk("int_req_reg", 0, int_req_reg);
    endtask
    task automatic expect_int(input int src);
        int k;
        for (k = 0; k < 12 && int_req_reg !== 1'b1; k++) cyc(1);
        chk("int_vector_reg", 16'hFFFC - 2 * src, int_vector_reg);
        chk("int_priority_reg", src, int_priority_reg);
        chk("global_mask_reg", 1, global_mask_reg);
        for (k = 0; k < 12 && int_req_reg !== 1'b0; k++) cyc(1);
        chk("int_req_reg", 0, int_req_reg);
    endtask
    task automatic test_done();
        $display("counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset();
        chk("int_vector_reg", 16'hFFFE, int_vector_reg);
        chk("global_mask_reg", 1, global_mask_reg);
        chk("flags_reg", 0, flags_reg);
        fire(2);
        quiet();
        fire(14);
        expect_int(0);
        fire(13);
        expect_int(0);
        clean();
        $display("t_reset done");
    endtask
    task automatic t_sources();
        for (int i = 0; i < 13; i++) begin
            en = 0;
            fire(i);
            chk("flags_reg bit", 1, flags_reg[fl[i]]);
            quiet();
            en = '1;
            expect_int(sr[i]);
            clean();
        end
        $display("t_sources done");
    endtask
    task automatic t_overrun();
        msk(1);
        fire(6);
        fire(6);
        fire(9);
        fire(9);
        chk("sync overflow", 1, flags_reg[9]);
        chk("async overrun", 1, flags_reg[12]);
        clean();
        $display("t_overrun done");
    endtask
    task automatic t_prio();
        int nx[5] = '{8, 13, 14, 15, 16};
        logic [19:0] cl[5] = '{20'h00001, 20'h00080, 20'h40000, 20'h0, 20'h0};
        msk(1);
        fire(5);
        fire(8);
        lv = 3'b111;
        ext_request_pin_n = 1'b0;
        cyc(4);
        msk(0);
        expect_int(1);
        ext_request_pin_n = 1'b1;
        cyc(4);
        for (int j = 0; j < 5; j++) begin
            flag_clear = cl[j];
            if (j > 2) lv[j-3] = 1'b0;
            cyc(1);
            flag_clear = 0;
            msk(0);
            expect_int(nx[j]);
        end
        lv = 0;
        clean();
        $display("t_prio done");
    endtask
    task automatic t_misc();
        msk(1);
        for (int j = 0; j < 2; j++) begin
            lock_indicator = j[0];
            cyc(4);
            chk("lock_change_flag", 1, flags_reg[1]);
            flag_clear = 20'h00002;
            cyc(1);
            flag_clear = 0;
        end
        sync_master = 1'b1;
        sync_select_pin = 1'b0;
        cyc(4);
        chk("master select fault", 1, flags_reg[10]);
        flag_clear = 20'h00400;
        cyc(1);
        flag_clear = 0;
        sync_master = 1'b0;
        sync_transfer_active = 1'b1;
        sync_select_pin = 1'b1;
        cyc(4);
        chk("slave select fault", 1, flags_reg[10]);
        async_tx_shift_empty = 1'b1;
        async_tx_data_empty = 1'b1;
        cyc(2);
        chk("async_tx_done_flag", 1, flags_reg[19]);
        async_rxd_pin = 1'b0;
        cyc(3);
        fire(15);
        async_rxd_pin = 1'b1;
        cyc(3);
        repeat (9) fire(15);
        chk("idle after 9", 0, flags_reg[17]);
        fire(15);
        chk("idle after 10", 1, flags_reg[17]);
        clean();
        $display("t_misc done");
    endtask
    task automatic t_gates();
        ext_request_mask = 1'b1;
        async_stop_bit = 1'b1;
        async_parity_fail = 1'b0;
        async_nine_bit = 1'b1;
        ext_request_pin_n = 1'b0;
        fire(11);
        fire(12);
        chk("frame on good stop", 0, flags_reg[14]);
        chk("parity on pass", 0, flags_reg[15]);
        chk("ext flag masked", 1, flags_reg[0]);
        ext_request_pin_n = 1'b1;
        quiet();
        ext_request_mask = 1'b0;
        expect_int(1);
        clean();
        msk(1);
        async_tx_shift_empty = 1'b0;
        async_break_idle_busy = 1'b1;
        cyc(2);
        async_tx_shift_empty = 1'b1;
        cyc(2);
        chk("done while break busy", 0, flags_reg[19]);
        async_break_idle_busy = 1'b0;
        cyc(2);
        chk("done after break", 1, flags_reg[19]);
        async_rxd_pin = 1'b0;
        cyc(3);
        fire(15);
        async_rxd_pin = 1'b1;
        cyc(3);
        repeat (10) fire(15);
        chk("idle after 10 long", 0, flags_reg[17]);
        fire(15);
        chk("idle after 11", 1, flags_reg[17]);
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        chk("flags_reg after reset", 0, flags_reg);
        chk("global_mask_reg after reset", 1, global_mask_reg);
        chk("int_vector_reg after reset", 16'hFFFE, int_vector_reg);
        $display("t_gates done");
    endtask
    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(3);
        t_reset();
        t_sources();
        t_overrun();
        t_prio();
        t_misc();
        t_gates();
        test_done();
    end
endmodule // pis_ctrl_tb
`default_nettype wire
